/* File: src/fpe_defs.svh */
// Offsets, field positions, reset values and timing counts of the frequency element
`ifndef FPE_DEFS_SVH
`define FPE_DEFS_SVH
`define FPE_ADDR_VBLOCK 8'h00
`define FPE_ADDR_WIN 8'h04
`define FPE_ADDR_STATUS 8'h08
`define FPE_ADDR_FREQ 8'h0C
`define FPE_ADDR_ELEM_BASE 8'h10
`define FPE_ELEM_STRIDE 8'h10
`define FPE_SUB_CFG 4'h0
`define FPE_SUB_FTHR 4'h4
`define FPE_SUB_GTHR 4'h8
`define FPE_WIN_MEAS_LSB 0
`define FPE_WIN_FSTAB_LSB 8
`define FPE_WIN_GSTAB_LSB 16
`define FPE_CFG_MODE_LSB 0
`define FPE_CFG_DIR_LSB 4
`define FPE_CFG_DELAY_LSB 16
`define FPE_VBLOCK_RST 16'h0100
`define FPE_WIN_MIN 4'h2
`define FPE_WIN_MAX 4'hA
`define FPE_FSTAB_RST 4'h3
`define FPE_GSTAB_RST 4'h1
`define FPE_NELEM 6
`define FPE_NPH 3
`define FPE_CLK_MHZ 250
`define FPE_BLK_HOLD_MS 500
`define FPE_FZERO_HOLD_MS 300
`define FPE_MS_CYC 250000
`endif

/* File: src/fpe_pkg.sv */
// Types shared by the frequency protection element
package fpe_pkg;
  typedef enum logic [2:0] {
    FPE_UNDERFREQ_MODE = 3'h0,
    FPE_OVERFREQ_MODE = 3'h1,
    FPE_GRADIENT_MODE = 3'h2,
    FPE_UNDERFREQ_WITH_GRADIENT_MODE = 3'h3,
    FPE_OVERFREQ_WITH_GRADIENT_MODE = 3'h4
  } fpe_mode_t;

  typedef enum logic [1:0] {
    FPE_DIR_POS = 2'h0,
    FPE_DIR_NEG = 2'h1,
    FPE_DIR_ABS = 2'h2
  } fpe_dir_t;

  // Values from the measuring front end, one lane per phase-to-phase voltage
  typedef struct packed {
    logic [2:0][15:0] freq_raw;
    logic [2:0] zero_cross;
    logic [15:0] line_voltage_ab;
    logic [15:0] line_voltage_bc;
    logic [15:0] line_voltage_ca;
  } fpe_meas_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] dir;
    logic [15:0] delay_ms;
    logic [15:0] freq_thr;
    logic signed [16:0] grad_thr;
  } fpe_cfg_t;
endpackage : fpe_pkg

/* File: src/fpe_top.sv */
// Six frequency protection elements with shared measurement, blocking and registers
//
// Summary of operation
// - Underfrequency: alarm as soon as frequency falls below pickup threshold.
// - Underfrequency: trip only if frequency stays below threshold for whole delay.
// - Overfrequency: alarm as soon as frequency rises above pickup threshold.
// - Overfrequency: trip only if frequency stays above threshold until delay ends.
// - Block frequency evaluation while all three line voltages are below threshold.
// - Alarm needs pickup in some phase and no blocking; alarm starts timer.
// - On timer expiry trip only if pickup still holds.
// - Gradient computed each voltage period, refreshed at every zero crossing.
// - Gradient window set in whole nominal periods, 2 to 10.
// - Gradient taken from raw frequency, before averaging and stabilising.
// - Separate stabilising window, in rated cycles, filters gradient fluctuations.
// - Gradient is signed: positive when rising, negative when falling.
// - Direction setting picks rising only, falling only, or both magnitudes.
// - Gradient mode: alarm on threshold crossing, trip if it persists to delay end.
// - Combined modes: alarm needs frequency and gradient pickup in same phase.
// - Combined modes: trip needs both conditions still true at expiry.
// - Blocking stays active at least 0.5 s after voltages recover.
// - Reported frequency held at zero at least 0.3 s after recovery.
// - Six independent elements, each with its own operating mode.
`timescale 1ns/1ps
`include "fpe_defs.svh"

module fpe_top #(
  parameter int unsigned BLK_HOLD_CYC = `FPE_BLK_HOLD_MS * 1000 * `FPE_CLK_MHZ,
  parameter int unsigned FZERO_HOLD_CYC = `FPE_FZERO_HOLD_MS * 1000 * `FPE_CLK_MHZ,
  parameter int unsigned MS_CYC = `FPE_MS_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire fpe_pkg::fpe_meas_t meas,
  input wire logic [5:0] ext_block,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [5:0] alarm,
  output logic [5:0] trip,
  output logic freq_blocked
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Keeps the gradient window inside its legal span of periods
  function automatic logic [3:0] fpe_clamp_win(input logic [3:0] w);
    if (w < `FPE_WIN_MIN) begin
      return `FPE_WIN_MIN;
    end else if (w > `FPE_WIN_MAX) begin
      return `FPE_WIN_MAX;
    end
    return w;
  endfunction : fpe_clamp_win

  // Gradient pickup in the selected direction
  function automatic logic fpe_grad_pick(input logic signed [16:0] g,
                                         input logic signed [16:0] thr,
                                         input logic [1:0] dir);
    logic signed [16:0] neg_g;
    neg_g = -g;
    case (dir)
      fpe_pkg::FPE_DIR_POS: return g > thr;
      fpe_pkg::FPE_DIR_NEG: return neg_g > thr;
      default: return (g > thr) || (neg_g > thr);
    endcase
  endfunction : fpe_grad_pick

  // Delay has fully run once ticks pass the setting: the first tick may fall anywhere
  // in the first millisecond, so one extra tick keeps the trip from coming early.
  // A zero delay trips at once.
  function automatic logic fpe_delay_done(input logic [16:0] ticks,
                                          input logic [15:0] delay);
    return (delay == 16'h0000) || (ticks > {1'b0, delay});
  endfunction : fpe_delay_done

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Register map, byte addresses, 32-bit words only:
  //   0x00  undervoltage threshold [15:0]
  //   0x04  gradient windows: measure [3:0], frequency stabilising [11:8],
  //         gradient stabilising [19:16]; the measure window is clamped on write
  //   0x08  status, read only: alarm [5:0], trip [13:8], blocked [16]
  //   0x0C  phase ab frequency as the elements see it, read only
  //   0x10 + 0x10 * i, element i = 0..5:
  //         +0 mode [2:0], direction [5:4], trip delay in ms [31:16]
  //         +4 frequency threshold [15:0]
  //         +8 gradient threshold magnitude [15:0]
  // Slots 6 and 7 and all unmapped words read as zero and ignore writes.
  // The frequency stabilising window is stored only; nothing filters the
  // frequency here, so a user who widens it sees no change in timing.
  // Modes 5 to 7 never pick up, so a stray mode write leaves an element idle.

  logic [15:0] vblock_r;
  logic [3:0] gradient_measure_window_r;
  logic [3:0] gradient_freq_stab_window_r;
  logic [3:0] gradient_stab_window_r;
  fpe_pkg::fpe_cfg_t cfg_r [`FPE_NELEM];
  logic [7:0] eoff;
  logic [2:0] eidx;
  logic [3:0] esub;
  logic ehit;

  // Element window decode, shared by write and read paths
  always_comb begin
    eoff = addr - `FPE_ADDR_ELEM_BASE;
    eidx = eoff[6:4];
    esub = eoff[3:0];
    // Bit 7 set means slot 8 or above, which must not alias onto slot 0
    ehit = (addr >= `FPE_ADDR_ELEM_BASE) && !eoff[7] && (eidx < 3'(`FPE_NELEM));
  end

  // Software writes; the window write is clamped so a bad value never reaches the history
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      vblock_r <= `FPE_VBLOCK_RST;
      gradient_measure_window_r <= `FPE_WIN_MIN;
      gradient_freq_stab_window_r <= `FPE_FSTAB_RST;
      gradient_stab_window_r <= `FPE_GSTAB_RST;
      for (int i = 0; i < `FPE_NELEM; i++) begin
        cfg_r[i] <= '0;
      end
    end else if (wr) begin
      if (addr == `FPE_ADDR_VBLOCK) begin
        vblock_r <= wdata[15:0];
      end
      if (addr == `FPE_ADDR_WIN) begin
        gradient_measure_window_r <= fpe_clamp_win(wdata[`FPE_WIN_MEAS_LSB +: 4]);
        gradient_freq_stab_window_r <= wdata[`FPE_WIN_FSTAB_LSB +: 4];
        gradient_stab_window_r <= wdata[`FPE_WIN_GSTAB_LSB +: 4];
      end
      if (ehit && esub == `FPE_SUB_CFG) begin
        cfg_r[eidx].mode <= wdata[`FPE_CFG_MODE_LSB +: 3];
        cfg_r[eidx].dir <= wdata[`FPE_CFG_DIR_LSB +: 2];
        cfg_r[eidx].delay_ms <= wdata[`FPE_CFG_DELAY_LSB +: 16];
      end
      if (ehit && esub == `FPE_SUB_FTHR) begin
        cfg_r[eidx].freq_thr <= wdata[15:0];
      end
      if (ehit && esub == `FPE_SUB_GTHR) begin
        cfg_r[eidx].grad_thr <= {1'b0, wdata[15:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Undervoltage blocking with hold after recovery

  logic uv_now;
  logic [26:0] rec_cnt_r;
  logic blocked_r;
  logic fzero_r;

  assign uv_now = (meas.line_voltage_ab < vblock_r) && (meas.line_voltage_bc < vblock_r) &&
                  (meas.line_voltage_ca < vblock_r);

  // Counts from recovery; saturates so it cannot wrap back into a block
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rec_cnt_r <= '0;
    end else if (uv_now) begin
      rec_cnt_r <= '0;
    end else if (rec_cnt_r != 27'(BLK_HOLD_CYC)) begin
      rec_cnt_r <= rec_cnt_r + 27'h0000001;
    end
  end

  // Block and frequency-zero flags; both start asserted since nothing is measured yet
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      blocked_r <= 1'b1;
      fzero_r <= 1'b1;
    end else begin
      blocked_r <= uv_now || (rec_cnt_r < 27'(BLK_HOLD_CYC));
      fzero_r <= uv_now || (rec_cnt_r < 27'(FZERO_HOLD_CYC));
    end
  end

  assign freq_blocked = blocked_r;

  ////////////////////////////////////////////////////////////////////////////
  // Gradient per phase

  logic [15:0] hist_r [`FPE_NPH][10];
  logic signed [16:0] grad_raw_r [`FPE_NPH];
  logic [3:0] stab_cnt_r [`FPE_NPH];
  logic signed [16:0] grad_use [`FPE_NPH];
  logic [15:0] freq_use [`FPE_NPH];

  // At each zero crossing, difference against the sample one window back
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < `FPE_NPH; p++) begin
        grad_raw_r[p] <= '0;
        stab_cnt_r[p] <= '0;
        for (int k = 0; k < 10; k++) begin
          hist_r[p][k] <= '0;
        end
      end
    end else begin
      for (int p = 0; p < `FPE_NPH; p++) begin
        if (meas.zero_cross[p]) begin
          hist_r[p][0] <= meas.freq_raw[p];
          for (int k = 1; k < 10; k++) begin
            hist_r[p][k] <= hist_r[p][k-1];
          end
          grad_raw_r[p] <= $signed({1'b0, meas.freq_raw[p]}) -
                           $signed({1'b0, hist_r[p][gradient_measure_window_r - 4'h1]});
          // Sign flips restart the stabilising count at 1, so with a window above 1 a one-period gradient of flipped sign never reaches pickup
          if ((grad_raw_r[p][16] == (meas.freq_raw[p] < hist_r[p][gradient_measure_window_r
              - 4'h1])) && stab_cnt_r[p] != 4'hF) begin
            stab_cnt_r[p] <= stab_cnt_r[p] + 4'h1;
          end else begin
            stab_cnt_r[p] <= 4'h1;
          end
        end
      end
    end
  end

  // Values seen by the elements; frequency forced to zero while zero hold runs, gradient while blocking or not yet stable
  always_comb begin
    for (int p = 0; p < `FPE_NPH; p++) begin
      freq_use[p] = fzero_r ? 16'h0000 : meas.freq_raw[p];
      grad_use[p] = (blocked_r || stab_cnt_r[p] < gradient_stab_window_r) ? 17'h00000 :
                    grad_raw_r[p];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pickup decision per element

  logic [5:0] pick;

  // A phase with zero frequency never gives frequency pickup; its gradient can still pick up
  always_comb begin
    logic fu;
    logic fo;
    logic gp;
    fu = 1'b0;
    fo = 1'b0;
    gp = 1'b0;
    for (int i = 0; i < `FPE_NELEM; i++) begin
      pick[i] = 1'b0;
      for (int p = 0; p < `FPE_NPH; p++) begin
        fu = (freq_use[p] != 16'h0000) && (freq_use[p] < cfg_r[i].freq_thr);
        fo = (freq_use[p] != 16'h0000) && (freq_use[p] > cfg_r[i].freq_thr);
        gp = fpe_grad_pick(grad_use[p], cfg_r[i].grad_thr, cfg_r[i].dir);
        case (cfg_r[i].mode)
          fpe_pkg::FPE_UNDERFREQ_MODE: pick[i] = pick[i] | fu;
          fpe_pkg::FPE_OVERFREQ_MODE: pick[i] = pick[i] | fo;
          fpe_pkg::FPE_GRADIENT_MODE: pick[i] = pick[i] | gp;
          fpe_pkg::FPE_UNDERFREQ_WITH_GRADIENT_MODE: pick[i] = pick[i] | (fu & gp);
          fpe_pkg::FPE_OVERFREQ_WITH_GRADIENT_MODE: pick[i] = pick[i] | (fo & gp);
          default: pick[i] = pick[i];
        endcase
      end
      pick[i] = pick[i] & ~blocked_r & ~ext_block[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and trip delay timers

  logic [17:0] ms_cnt_r;
  logic ms_tick_r;
  logic [16:0] timer_r [`FPE_NELEM];

  // Free-running tick; the delay is thus accurate to one millisecond, traded for small counters
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (ms_cnt_r == 18'(MS_CYC - 1));
      ms_cnt_r <= (ms_cnt_r == 18'(MS_CYC - 1)) ? 18'h00000 : ms_cnt_r + 18'h00001;
    end
  end

  // Alarm follows pickup; timer runs while alarm stands and clears with it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alarm <= '0;
      trip <= '0;
      for (int i = 0; i < `FPE_NELEM; i++) begin
        timer_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `FPE_NELEM; i++) begin
        if (!pick[i]) begin
          alarm[i] <= 1'b0;
          trip[i] <= 1'b0;
          timer_r[i] <= '0;
        end else begin
          alarm[i] <= 1'b1;
          // Timer parks once done, so a delay lowered mid-run still ends in a trip
          if (alarm[i] && ms_tick_r && !fpe_delay_done(timer_r[i], cfg_r[i].delay_ms)) begin
            timer_r[i] <= timer_r[i] + 17'h00001;
          end
          // Pickup is rechecked here, so a trip needs the condition at expiry
          if (alarm[i] && fpe_delay_done(timer_r[i], cfg_r[i].delay_ms)) begin
            trip[i] <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped addresses read as zero

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= 32'h00000000;
      if (rd) begin
        if (addr == `FPE_ADDR_VBLOCK) begin
          rdata <= {16'h0000, vblock_r};
        end else if (addr == `FPE_ADDR_WIN) begin
          rdata <= {12'h000, gradient_stab_window_r, 4'h0, gradient_freq_stab_window_r,
                    4'h0, gradient_measure_window_r};
        end else if (addr == `FPE_ADDR_STATUS) begin
          rdata <= {15'h0000, blocked_r, 2'h0, trip, 2'h0, alarm};
        end else if (addr == `FPE_ADDR_FREQ) begin
          rdata <= {16'h0000, freq_use[0]};
        end else if (ehit && esub == `FPE_SUB_CFG) begin
          rdata <= {cfg_r[eidx].delay_ms, 10'h000, cfg_r[eidx].dir, 1'b0, cfg_r[eidx].mode};
        end else if (ehit && esub == `FPE_SUB_FTHR) begin
          rdata <= {16'h0000, cfg_r[eidx].freq_thr};
        end else if (ehit && esub == `FPE_SUB_GTHR) begin
          rdata <= {16'h0000, cfg_r[eidx].grad_thr[15:0]};
        end
      end
    end
  end

endmodule : fpe_top

/* File: tb/fpe_meas_model.sv */
// Behavioural measuring front end: per-phase frequency and line voltages
`timescale 1ns/1ps
module fpe_meas_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [2:0][15:0] f_set,
  input wire logic signed [15:0] step,
  input wire logic [15:0] v_lvl,
  output fpe_pkg::fpe_meas_t meas
);
  logic [3:0] ph_cnt_r;
  ////////////////////////////////////////
  // Phase counter, one crossing per phase every 16 cycles, staggered by 4
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) ph_cnt_r <= 4'h0;
    else ph_cnt_r <= ph_cnt_r + 4'h1;
  end
  // Frequency tracks the set value, or ramps one step per crossing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meas <= '0;
    end else begin
      meas.line_voltage_ab <= v_lvl;
      meas.line_voltage_bc <= v_lvl;
      meas.line_voltage_ca <= v_lvl;
      for (int p = 0; p < 3; p++) begin
        meas.zero_cross[p] <= ph_cnt_r == 4'(p * 4);
        if (step == 16'sh0) meas.freq_raw[p] <= f_set[p];
        else if (ph_cnt_r == 4'(p * 4)) meas.freq_raw[p] <= meas.freq_raw[p] + 16'(step);
      end
    end
  end
endmodule : fpe_meas_model

/* File: tb/fpe_chk.sv */
// Port assertions for the frequency protection element
`timescale 1ns/1ps
module fpe_chk #(
  parameter int unsigned BLK_HOLD_CYC = 200
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire fpe_pkg::fpe_meas_t meas,
  input wire logic [5:0] ext_block,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [5:0] alarm,
  input wire logic [5:0] trip,
  input wire logic freq_blocked
);
  logic [15:0] vthr_r;
  int unsigned ok_cnt_r;
  logic vlow;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Shadow of the undervoltage threshold register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) vthr_r <= 16'h0100;
    else if (wr && addr == 8'h00) vthr_r <= wdata[15:0];
  end
  // All three line voltages low
  assign vlow = meas.line_voltage_ab < vthr_r && meas.line_voltage_bc < vthr_r &&
    meas.line_voltage_ca < vthr_r;
  // Healthy-voltage cycles; saturates so long runs cannot wrap
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) ok_cnt_r <= 0;
    else if (vlow) ok_cnt_r <= 0;
    else if (ok_cnt_r < BLK_HOLD_CYC) ok_cnt_r <= ok_cnt_r + 1;
  end
  sequence s_released;
    $fell(freq_blocked);
  endsequence
  ////////////////////////////////////////
  a_blk_follow: assert property (vlow |=> freq_blocked)
    else $error("block missed on low voltage");
  a_blk_cause: assert property ($rose(freq_blocked) |-> $past(vlow))
    else $error("block without low voltage");
  a_blk_hold: assert property (s_released |-> ok_cnt_r >= BLK_HOLD_CYC - 1)
    else $error("block released early");
  a_block_idle: assert property (freq_blocked |=> alarm == 6'h00)
    else $error("alarm while blocked");
  a_ext_idle: assert property ((alarm & $past(ext_block)) == 6'h00)
    else $error("alarm under external block");
  a_trip_alarm: assert property ((trip & ~alarm) == 6'h00)
    else $error("trip without alarm");
  a_trip_after: assert property ((trip & ~$past(trip) & ~$past(alarm)) == 6'h00)
    else $error("trip before alarm");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside slot");
endmodule : fpe_chk
bind fpe_top fpe_chk #(.BLK_HOLD_CYC(BLK_HOLD_CYC)) fpe_chk_inst (.mclk(mclk),
  .reset_n(reset_n), .meas(meas), .ext_block(ext_block), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .alarm(alarm), .trip(trip), .freq_blocked(freq_blocked));

/* File: tb/fpe_tb_top.sv */
// Self-checking testbench for the frequency protection element
`timescale 1ns/1ps
module fpe_tb_top;
  localparam int MS = 10;
  logic mclk, reset_n, wr, rd, freq_blocked;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [5:0] ext_block, alarm, trip;
  logic [2:0][15:0] f_set;
  logic signed [15:0] step;
  logic [15:0] v_lvl;
  fpe_pkg::fpe_meas_t meas;
  int err_total, cmp_count, t, n, fp;
  fpe_meas_model fpe_meas_model_inst (.mclk(mclk), .reset_n(reset_n), .f_set(f_set),
    .step(step), .v_lvl(v_lvl), .meas(meas));
  fpe_top #(.BLK_HOLD_CYC(200), .FZERO_HOLD_CYC(120), .MS_CYC(MS)) fpe_top_inst (.mclk(mclk),
    .reset_n(reset_n), .meas(meas), .ext_block(ext_block), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .alarm(alarm), .trip(trip), .freq_blocked(freq_blocked));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'h0;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    rd <= 1'h1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'h0;
    #1 chk("rdata", e, rdata);
  endtask : rd_chk
  task automatic cfg(input int i, input logic [2:0] m, input logic [1:0] d,
    input logic [15:0] dl, input logic [15:0] ft, input logic [15:0] gt);
    wr_reg(8'h10 + 8'(i * 16), {dl, 10'h000, d, 1'h0, m});
    wr_reg(8'h14 + 8'(i * 16), {16'h0000, ft});
    wr_reg(8'h18 + 8'(i * 16), {16'h0000, gt});
  endtask : cfg
  // Reference pickup decision, integers only
  function automatic bit pick(int m, int d, int f, int ft, int g, int gt);
    bit fu = f < ft && f != 0;
    bit gp = d == 0 ? g > gt : d == 1 ? -g > gt : (g > gt || -g > gt);
    case (m)
      0: return fu;
      1: return f > ft;
      2: return gp;
      3: return fu && gp;
      4: return f > ft && gp;
      default: return 1'h0;
    endcase
  endfunction : pick
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////
  // Free-running 250 MHz clock
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    finish_test;
  end
  // Main sequence
  initial begin
    void'($urandom(78));
    {reset_n, wr, rd, addr, wdata, ext_block, step} = '0;
    f_set = {3{16'h1388}};
    v_lvl = 16'h4000;
    repeat (20) @(posedge mclk);
    reset_n <= 1'h1;
    cyc(1);
    chk("blocked", 32'h1, freq_blocked);
    rd_chk(8'h00, 32'h100);
    rd_chk(8'h04, 32'h10302);
    rd_chk(8'h70, 32'h0);
    rd_chk(8'h0C, 32'h0);
    wr_reg(8'h04, 32'h1030F);
    rd_chk(8'h04, 32'h1030A);
    wr_reg(8'h04, 32'h10301);
    rd_chk(8'h04, 32'h10302);
    while (freq_blocked !== 1'h0 && $time < 1200) cyc(1);
    chk("hold", 32'h1, freq_blocked === 1'h0 && $time >= 80 + 4 * 199);
    rd_chk(8'h0C, 32'h1388);
    // Under and over frequency: pickup, abort, restart, trip time, external block
    for (int k = 0; k < 2; k++) begin
      t = 5000 + (k ? 1 : -1) * int'($urandom_range(200, 1));
      fp = k ? t + 5 : t - 5;
      cfg(k, 3'(k), 2'h0, 16'h0003, 16'(t), 16'h0000);
      cyc(3);
      chk("alarm_idle", 32'h0, alarm[k]);
      @(posedge mclk);
      f_set[1] <= 16'(fp);
      cyc(3);
      chk("alarm", 32'(pick(k, 0, fp, t, 0, 0)), alarm[k]);
      cyc(15);
      f_set[1] <= 16'h1388;
      cyc(3);
      chk("abort", 32'h0, {alarm[k], trip[k]});
      f_set[1] <= 16'(fp);
      n = 0;
      while (trip[k] !== 1'h1 && n < 100) begin
        cyc(1);
        n++;
      end
      chk("trip_time", 32'h1, n >= 3 * MS + 2 && n <= 4 * MS + 4);
      @(posedge mclk);
      ext_block[k] <= 1'h1;
      cyc(2);
      chk("ext_block", 32'h0, {alarm[k], trip[k]});
      @(posedge mclk);
      f_set[1] <= 16'h1388;
      cyc(2);
      @(posedge mclk);
      ext_block[k] <= 1'h0;
    end
    // Gradient and combined modes over both ramp signs and all directions
    for (int s = 0; s < 2; s++) begin
      @(posedge mclk);
      step <= s ? -16'sh1E : 16'sh1E;
      for (int d = 0; d < 3; d++) begin
        for (int e = 2; e < 5; e++) cfg(e, 3'(e), 2'(d), 16'h0, 16'hFFFF, 16'h32);
        cyc(80);
        for (int e = 2; e < 5; e++)
          chk("grad", pick(e, d, 5000, 65535, s ? -60 : 60, 50) ? 32'h3 : 32'h0,
            {alarm[e], trip[e]});
      end
    end
    @(posedge mclk);
    step <= 16'sh0;
    v_lvl <= 16'h00FF;
    cyc(4);
    chk("uv_block", 32'h1, {alarm, freq_blocked});
    rd_chk(8'h08, 32'h10000);
    rd_chk(8'h0C, 32'h0);
    finish_test;
  end
endmodule : fpe_tb_top
